/* design/pds_pin_share.sv */
/*
 * Pin sharing for port four bits 0..6 and port five bits 0..1.
 * Assumes memory interface and serial channels on the same clock;
 * pad inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pds_regs.svh"

module pds_pin_share
	import pds_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Port four configuration writes
	input  wire logic                  p4_wr,
	input  wire pds_p4_cfg_type        p4_cfg_in,
	// Port five configuration writes
	input  wire logic                  p5_wr,
	input  wire pds_p5_cfg_type        p5_cfg_in,
	// Memory interface
	input  wire logic [`PDS_CS_W-1:0]  mem_sel_n,
	input  wire logic                  mem_bus_active,
	input  wire logic                  bus_drive_keep_bit,
	// Serial channels
	input  wire logic                  serial_zero_tx,
	input  wire logic                  serial_one_tx,
	output logic                       serial_zero_rx,
	// Pad inputs
	input  wire logic [`PDS_P4_W-1:0]  p4_pad_i,
	input  wire logic [`PDS_P5_W-1:0]  p5_pad_i,
	// Pad drive
	output logic [`PDS_P4_W-1:0]       p4_pad_o,
	output logic [`PDS_P4_W-1:0]       p4_pad_oe_n,
	output logic [`PDS_P4_W-1:0]       p4_pad_pu,
	output logic [`PDS_P5_W-1:0]       p5_pad_o,
	output logic [`PDS_P5_W-1:0]       p5_pad_oe_n,
	output logic [`PDS_P5_W-1:0]       p5_pad_pu,
	// GPIO readback
	output logic [`PDS_P4_W-1:0]       p4_in,
	output logic [`PDS_P5_W-1:0]       p5_in,
	output pds_p4_cfg_type             p4_cfg,
	output pds_p5_cfg_type             p5_cfg
);
	// ****************************************
	// Configuration registers
	// ****************************************
	pds_p4_cfg_type p4_cfg_reg;
	pds_p4_cfg_type p4_cfg_next;
	pds_p5_cfg_type p5_cfg_reg;
	pds_p5_cfg_type p5_cfg_next;

	always_comb begin
		p4_cfg_next = p4_cfg_reg;
		p5_cfg_next = p5_cfg_reg;
		if (p4_wr) begin
			p4_cfg_next = p4_cfg_in;
		end
		if (p5_wr) begin
			p5_cfg_next = p5_cfg_in;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p4_cfg_reg.per <= `PDS_P4_PER_RST;
			p4_cfg_reg.dir <= `PDS_P4_DIR_RST;
			p4_cfg_reg.dat <= `PDS_P4_DAT_RST;
			p4_cfg_reg.pur <= `PDS_P4_PUR_RST;
			p5_cfg_reg.per <= `PDS_P5_PER_RST;
			p5_cfg_reg.dir <= `PDS_P5_DIR_RST;
			p5_cfg_reg.dat <= `PDS_P5_DAT_RST;
			p5_cfg_reg.pur <= `PDS_P5_PUR_RST;
		end else begin
			p4_cfg_reg <= p4_cfg_next;
			p5_cfg_reg <= p5_cfg_next;
		end
	end

	assign p4_cfg = p4_cfg_reg;
	assign p5_cfg = p5_cfg_reg;

	// ****************************************
	// Peripheral drive per pin
	// ****************************************
	logic [`PDS_P4_W-1:0] p4_per_o;
	logic [`PDS_P4_W-1:0] p4_per_oe;
	logic [`PDS_P5_W-1:0] p5_per_o;
	logic [`PDS_P5_W-1:0] p5_per_oe;
	logic                 cs_oe;

	always_comb begin
		cs_oe = mem_bus_active | bus_drive_keep_bit;
		p4_per_o  = {serial_one_tx, mem_sel_n};
		p4_per_oe = {1'b1, {`PDS_CS_W{cs_oe}}};
		p5_per_o  = {1'b0, serial_zero_tx};
		p5_per_oe = 2'h1;
	end

	// ****************************************
	// Pad cells
	// ****************************************
	pds_pad_type p4_pad [`PDS_P4_W];
	pds_pad_type p5_pad [`PDS_P5_W];

	for (genvar i = 0; i < `PDS_P4_W; i++) begin : g_p4
		pds_pad_cell u_cell (
			.clk      (clk),
			.rst_n    (rst_n),
			.per_en   (p4_cfg_reg.per[i]),
			.gpio_dir (p4_cfg_reg.dir[i]),
			.gpio_dat (p4_cfg_reg.dat[i]),
			.pu_en    (p4_cfg_reg.pur[i]),
			.per_o    (p4_per_o[i]),
			.per_oe   (p4_per_oe[i]),
			.pad      (p4_pad[i])
		);
		assign p4_pad_o[i]    = p4_pad[i].o;
		assign p4_pad_oe_n[i] = p4_pad[i].oe_n;
		assign p4_pad_pu[i]   = p4_pad[i].pu;
	end

	for (genvar j = 0; j < `PDS_P5_W; j++) begin : g_p5
		pds_pad_cell u_cell (
			.clk      (clk),
			.rst_n    (rst_n),
			.per_en   (p5_cfg_reg.per[j]),
			.gpio_dir (p5_cfg_reg.dir[j]),
			.gpio_dat (p5_cfg_reg.dat[j]),
			.pu_en    (p5_cfg_reg.pur[j]),
			.per_o    (p5_per_o[j]),
			.per_oe   (p5_per_oe[j]),
			.pad      (p5_pad[j])
		);
		assign p5_pad_o[j]    = p5_pad[j].o;
		assign p5_pad_oe_n[j] = p5_pad[j].oe_n;
		assign p5_pad_pu[j]   = p5_pad[j].pu;
	end

	// ****************************************
	// Input synchronisers and receive path
	// ****************************************
	logic [`PDS_P4_W-1:0] p4_sync;
	logic [`PDS_P5_W-1:0] p5_sync;
	logic                 rx_next;

	pds_sync2 #(.W(`PDS_P4_W)) u_sync4 (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (p4_pad_i),
		.q     (p4_sync)
	);

	pds_sync2 #(.W(`PDS_P5_W)) u_sync5 (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (p5_pad_i),
		.q     (p5_sync)
	);

	always_comb begin
		// Idle high when pin is GPIO
		rx_next = p5_cfg_reg.per[`PDS_S0_RX_BIT] ?
			p5_sync[`PDS_S0_RX_BIT] : 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p4_in          <= '0;
			p5_in          <= '0;
			serial_zero_rx <= 1'b1;
		end else begin
			p4_in          <= p4_sync;
			p5_in          <= p5_sync;
			serial_zero_rx <= rx_next;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence cfg4_write_s;
		p4_wr ##1 1'b1;
	endsequence

	sequence cfg5_write_s;
		p5_wr ##1 1'b1;
	endsequence

	gpio_dir_follow_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p4_wr && !p4_cfg_in.per[0]
		|-> ##2 p4_pad_oe_n[0] == !$past(p4_cfg_in.dir[0], 2))
		else $error("gpio direction not applied");
	gpio_dir_bit_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!p4_cfg_reg.per[5]
		|=> p4_pad_oe_n[5] == !$past(p4_cfg_reg.dir[5]))
		else $error("gpio direction bit not applied");
	cs_map_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p4_cfg_reg.per[2]
		|=> p4_pad_o[2] == $past(mem_sel_n[2]))
		else $error("memory select not routed");
	cs_map_hi_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p4_cfg_reg.per[5]
		|=> p4_pad_o[5] == $past(mem_sel_n[5]))
		else $error("last memory select not routed");
	cs_float_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p4_cfg_reg.per[0] && !mem_bus_active && !bus_drive_keep_bit
		|=> p4_pad_oe_n[0])
		else $error("memory select driven while idle");
	cs_drive_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p4_cfg_reg.per[1] && mem_bus_active
		|=> !p4_pad_oe_n[1])
		else $error("memory select floats during transfer");
	reset_func_a: assert property (
		@(posedge clk)
		$rose(rst_n) |-> p4_cfg_reg.per == `PDS_P4_PER_RST
		&& p5_cfg_reg.per == `PDS_P5_PER_RST)
		else $error("wrong reset pin function");
	gpio_reset_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n)
		|=> p4_pad_oe_n[5:0] == 6'h3F)
		else $error("select pins not gpio inputs after reset");
	p4_pullup_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		cfg4_write_s
		|=> p4_pad_pu == $past(p4_cfg_in.pur, 2))
		else $error("port four pull-up not applied");
	s0_tx_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p5_cfg_reg.per[0]
		|=> p5_pad_o[0] == $past(serial_zero_tx) && !p5_pad_oe_n[0])
		else $error("serial zero transmit not routed");
	s0_rx_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p5_cfg_reg.per[1]
		|=> p5_pad_oe_n[1])
		else $error("serial zero receive pin driven");
	rx_follow_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p5_cfg_reg.per[1]
		|=> serial_zero_rx == p5_in[1])
		else $error("serial zero receive not from pin");
	rx_idle_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!p5_cfg_reg.per[1]
		|=> serial_zero_rx)
		else $error("serial zero receive not idle");
	s1_tx_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p4_cfg_reg.per[6]
		|=> p4_pad_o[6] == $past(serial_one_tx) && !p4_pad_oe_n[6])
		else $error("serial one transmit not routed");
	serial_reset_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n)
		|=> !p4_pad_oe_n[6] && !p5_pad_oe_n[0] && p5_pad_oe_n[1])
		else $error("serial pins not serial after reset");
	handed_pin_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!p5_cfg_reg.per[0]
		|=> p5_pad_o[0] == $past(p5_cfg_reg.dat[0]))
		else $error("gpio data not on pad");
	serial_dir_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!p4_cfg_reg.per[6]
		|=> p4_pad_oe_n[6] == !$past(p4_cfg_reg.dir[6]))
		else $error("serial pin gpio direction not applied");
	p5_pullup_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		1'b1
		|=> p5_pad_pu == $past(p5_cfg_reg.pur))
		else $error("port five pull-up not applied");
	s0_pullup_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		cfg5_write_s
		|=> p5_pad_pu == $past(p5_cfg_in.pur, 2))
		else $error("serial zero pull-up write not applied");
	s1_pullup_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		cfg4_write_s
		|=> p4_pad_pu[6] == $past(p4_cfg_in.pur[6], 2))
		else $error("serial one pull-up not applied");
	per_handoff_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p4_wr && p4_cfg_in.per[3]
		|-> ##2 p4_pad_o[3] == $past(mem_sel_n[3]))
		else $error("peripheral enable did not hand over pin");
	per_owns_oe_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		p4_cfg_reg.per[4]
		|=> p4_pad_oe_n[4] ==
		!$past(mem_bus_active || bus_drive_keep_bit))
		else $error("handed pin enable not from peripheral");
endmodule

`default_nettype wire

/* design/pds_regs.svh */
/*
 * Constants for the port four / port five pin sharing block.
 * Assumes inclusion by bare name from design and testbench files.
 */
`ifndef PDS_REGS_SVH
`define PDS_REGS_SVH

// ****************************************
// Widths and pin positions
// ****************************************
`define PDS_P4_W        7
`define PDS_P5_W        2
`define PDS_CS_W        6
`define PDS_S1_TX_BIT   6
`define PDS_S0_TX_BIT   0
`define PDS_S0_RX_BIT   1

// ****************************************
// Reset values
// ****************************************
`define PDS_P4_PER_RST  7'h40
`define PDS_P5_PER_RST  2'h3
`define PDS_P4_PUR_RST  7'h7F
`define PDS_P5_PUR_RST  2'h3
`define PDS_P4_DIR_RST  7'h00
`define PDS_P5_DIR_RST  2'h0
`define PDS_P4_DAT_RST  7'h00
`define PDS_P5_DAT_RST  2'h0

`endif

/* design/pds_pkg.sv */
/*
 * Types for the pin sharing block.
 * Assumes pds_regs.svh sits beside it.
 */
`include "pds_regs.svh"

package pds_pkg;
	// ****************************************
	// Per-port configuration
	// ****************************************
	typedef struct packed {
		logic [`PDS_P4_W-1:0] per;
		logic [`PDS_P4_W-1:0] dir;
		logic [`PDS_P4_W-1:0] dat;
		logic [`PDS_P4_W-1:0] pur;
	} pds_p4_cfg_type;

	typedef struct packed {
		logic [`PDS_P5_W-1:0] per;
		logic [`PDS_P5_W-1:0] dir;
		logic [`PDS_P5_W-1:0] dat;
		logic [`PDS_P5_W-1:0] pur;
	} pds_p5_cfg_type;

	// ****************************************
	// Pad drive bundle
	// ****************************************
	typedef struct packed {
		logic o;
		logic oe_n;
		logic pu;
	} pds_pad_type;
endpackage

/* design/pds_sync2.sv */
/*
 * Two-flop synchroniser for pin inputs.
 * Assumes a single clock domain, async active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module pds_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;

	always_comb begin
		meta_next = d;
		q_next    = meta_reg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= meta_next;
			q        <= q_next;
		end
	end
endmodule

`default_nettype wire

/* design/pds_pad_cell.sv */
/*
 * One shared pad: selects GPIO or peripheral drive.
 * Assumes peripheral drive arrives on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module pds_pad_cell
	import pds_pkg::*;
(
	// Clock and reset
	input  wire logic    clk,
	input  wire logic    rst_n,
	// Configuration
	input  wire logic    per_en,
	input  wire logic    gpio_dir,
	input  wire logic    gpio_dat,
	input  wire logic    pu_en,
	// Peripheral drive
	input  wire logic    per_o,
	input  wire logic    per_oe,
	// Pad
	output pds_pad_type  pad
);
	pds_pad_type pad_next;

	always_comb begin
		pad_next.pu = pu_en;
		if (per_en) begin
			pad_next.o    = per_o;
			pad_next.oe_n = ~per_oe;
		end else begin
			pad_next.o    = gpio_dat;
			pad_next.oe_n = ~gpio_dir;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad <= '{o: 1'b0, oe_n: 1'b1, pu: 1'b1};
		end else begin
			pad <= pad_next;
		end
	end
endmodule

`default_nettype wire

/* tb/pds_far_side.sv */
/*
 * Far-side model: memory, serial line and other pad parties.
 * Assumes pad drive as {port five, port four}; oe_n low = device drives.
 */
`timescale 1ns/100ps
`default_nettype none

module pds_far_side (
	// Clock
	input  wire logic       clk,
	// Device pad drive
	input  wire logic [8:0] o,
	input  wire logic [8:0] oe_n,
	input  wire logic [8:0] pu,
	// Far-side drive
	input  wire logic [8:0] x,
	input  wire logic [8:0] x_en,
	// Pad levels
	output var  logic [8:0] pad
);
	logic tgl_reg = 1'b0;

	always @(posedge clk) begin
		tgl_reg <= ~tgl_reg;
	end

	// Device, then far side, then pull-up, else floating
	always_comb begin
		for (int n = 0; n < 9; n++)
			pad[n] = !oe_n[n] ? o[n] : x_en[n] ? x[n] : pu[n] ? 1'b1 : tgl_reg;
	end
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
 * Self-checking bench for the pin sharing block.
 * Assumes the design package and pds_far_side are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pds_regs.svh"

module testbench
	import pds_pkg::*;
;
	typedef struct packed {
		pds_p4_cfg_type c4;
		pds_p5_cfg_type c5;
		logic [8:0]     o, oe, pu, om, lv, lm;
		logic           rx, rxm;
	} pds_exp_type;

	logic           clk, rst_n, p4_wr, p5_wr, act, keep, s0tx, s1tx, s0rx, chk;
	pds_p4_cfg_type c4_in, c4m, p4_cfg;
	pds_p5_cfg_type c5_in, c5m, p5_cfg;
	logic [5:0]     sel_n;
	logic [8:0]     x, x_en;
	wire logic [8:0] pad_i, pad_o, pad_oe_n, pad_pu, pin_in;
	logic [31:0]    r;
	int             err_count, cmp_count;
	int             cyc = 0;
	pds_exp_type    q[$];
	pds_exp_type    e_mon;

	// ****************************************
	// Design and far side
	// ****************************************
	pds_pin_share u_pds_pin_share (.clk(clk), .rst_n(rst_n),
		.p4_wr(p4_wr), .p4_cfg_in(c4_in), .p5_wr(p5_wr), .p5_cfg_in(c5_in),
		.mem_sel_n(sel_n), .mem_bus_active(act), .bus_drive_keep_bit(keep),
		.serial_zero_tx(s0tx), .serial_one_tx(s1tx), .serial_zero_rx(s0rx),
		.p4_pad_i(pad_i[6:0]), .p5_pad_i(pad_i[8:7]),
		.p4_pad_o(pad_o[6:0]), .p5_pad_o(pad_o[8:7]),
		.p4_pad_oe_n(pad_oe_n[6:0]), .p5_pad_oe_n(pad_oe_n[8:7]),
		.p4_pad_pu(pad_pu[6:0]), .p5_pad_pu(pad_pu[8:7]),
		.p4_in(pin_in[6:0]), .p5_in(pin_in[8:7]),
		.p4_cfg(p4_cfg), .p5_cfg(p5_cfg));

	pds_far_side u_pds_far_side (.clk(clk), .o(pad_o), .oe_n(pad_oe_n),
		.pu(pad_pu), .x(x), .x_en(x_en), .pad(pad_i));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic pds_exp_type calc();
		pds_exp_type e;
		e = '0;
		e.c4 = c4m;
		e.c5 = c5m;
		for (int n = 0; n < 6; n++)
			e.o[n] = c4m.per[n] ? sel_n[n] : c4m.dat[n];
		e.o[6] = c4m.per[6] ? s1tx : c4m.dat[6];
		e.o[7] = c5m.per[0] ? s0tx : c5m.dat[0];
		e.o[8] = c5m.dat[1];
		e.oe = ({c5m.per, c4m.per} & {3'h4, {6{~(act | keep)}}})
			| (~{c5m.per, c4m.per} & ~{c5m.dir, c4m.dir});
		e.pu = {c5m.pur, c4m.pur};
		e.om = ~e.oe;
		e.lv = (~e.oe & e.o) | (e.oe & x_en & x) | (e.oe & ~x_en);
		e.lm = ~e.oe | x_en | e.pu;
		e.rx = c5m.per[1] ? e.lv[8] : 1'b1;
		e.rxm = ~c5m.per[1] | e.lm[8];
		return e;
	endfunction

	task automatic cmp_cfg(input logic [35:0] g, input logic [35:0] w);
		cmp_count++;
		if (g !== w) begin
			err_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, g, w);
		end
	endtask

	task automatic cmp_pin(input logic [8:0] g, w, m);
		cmp_count++;
		if ((g & m) !== (w & m)) begin
			err_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, g, w);
		end
	endtask

	task automatic do_reset();
		rst_n = 1'b0;
		c4m = {`PDS_P4_PER_RST, `PDS_P4_DIR_RST, `PDS_P4_DAT_RST, `PDS_P4_PUR_RST};
		c5m = {`PDS_P5_PER_RST, `PDS_P5_DIR_RST, `PDS_P5_DAT_RST, `PDS_P5_PUR_RST};
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
	endtask

	// Entered and left just after a rising edge
	task automatic apply(input logic w4, input logic w5, input logic b2b);
		p4_wr = w4;
		p5_wr = w5;
		repeat (b2b ? 2 : 1) begin
			r = lfsr(r);
			c4_in = r[27:0];
			c5_in = r[31:24];
			if (w4) c4m = c4_in;
			if (w5) c5m = c5_in;
			@(posedge clk);
			#1;
		end
		p4_wr = 1'b0;
		p5_wr = 1'b0;
		r = lfsr(r);
		{sel_n, act, keep, s0tx, s1tx} = r[9:0];
		x = r[18:10];
		x_en = r[27:19];
		repeat (5) @(posedge clk);
		#1;
		q.push_back(calc());
		chk = 1'b1;
		@(posedge clk);
		#1;
		chk = 1'b0;
	endtask

	task automatic end_sim();
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ****************************************
	// Result watcher
	// ****************************************
	always @(negedge clk) begin
		if (chk) begin
			e_mon = q.pop_front();
			cmp_cfg({p4_cfg, p5_cfg}, {e_mon.c4, e_mon.c5});
			cmp_pin(pad_o, e_mon.o, e_mon.om);
			cmp_pin(pad_oe_n, e_mon.oe, 9'h1FF);
			cmp_pin(pad_pu, e_mon.pu, 9'h1FF);
			cmp_pin(pin_in, e_mon.lv, e_mon.lm);
			cmp_pin({8'h00, s0rx}, {8'h00, e_mon.rx}, {8'h00, e_mon.rxm});
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			end_sim();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		r = 32'h01C5D2BA;
		{err_count, cmp_count} = '0;
		{chk, p4_wr, p5_wr, act, keep, s0tx, s1tx} = '0;
		{c4_in, c5_in, x, x_en} = '0;
		sel_n = 6'h3F;
		do_reset();
		apply(1'b0, 1'b0, 1'b0);
		repeat (60) apply(r[3], r[5], r[7]);
		do_reset();
		apply(1'b0, 1'b0, 1'b0);
		end_sim();
	end
endmodule
`default_nettype wire
